// file: hdl/lcd_timing_ctrl.sv
// LCD timing controller: parameter registers, raster timing and memory addressing
`timescale 1ns/1ps
`default_nettype none
module lcd_timing_ctrl
(
    // Clock and resets
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire logic                                   reset_n_pin,
    // Host register bus
    input  wire logic                                   cs_n,
    input  wire logic                                   reg_select_pin,
    input  wire logic                                   wr_n,
    input  wire logic                                   rd_n,
    input  wire logic [7:0]                             db_in,
    output var  logic [7:0]                             db_out,
    output logic                                        db_oe,
    // Mode pins
    input  wire logic                                   on_off_pin,
    input  wire logic                                   graphic_pin,
    input  wire logic                                   wide_pin,
    input  wire logic                                   blink_allow,
    input  wire logic                                   attr_enable,
    output var  logic [4:0]                             eff_mode,
    // Memory and LCD timing
    output var  logic [lcd_timing_pkg::ADDR_W-1:0]      mem_addr,
    output var  logic [lcd_timing_pkg::RASTER_W-1:0]    raster_addr,
    output var  logic                                   mem_clk,
    output var  logic                                   line_latch_clk,
    output var  logic                                   shift_clk,
    output var  logic                                   disp_timing,
    output var  logic                                   cursor_disp,
    output var  logic                                   frame_marker
);
    import lcd_timing_pkg::*;

    typedef struct packed {
        logic [4:0]             index_select;
        logic [7:0]             horizontal_total;
        logic [7:0]             horizontal_displayed;
        logic [4:0]             max_raster;
        logic [6:0]             cursor_start_blink;
        logic [4:0]             cursor_end;
        logic [7:0]             start_addr_high;
        logic [7:0]             start_addr_low;
        logic [7:0]             cursor_addr_high;
        logic [7:0]             cursor_addr_low;
        logic [7:0]             virtual_width;
        logic                   duty_high;
        logic [7:0]             duty_low;
        logic [4:0]             first_raster;
        logic [4:0]             display_mode;
        logic                   wr_low_prev;
        logic [1:0]             div;
        logic [7:0]             hcnt;
        logic [RASTER_W-1:0]    ras;
        logic [DUTY_W-1:0]      line;
        logic [ADDR_W-1:0]      row_addr;
        logic [REFRESH_W-1:0]   refresh;
        logic [FRAME_W-1:0]     frame;
        logic [7:0]             db_out;
        logic [ADDR_W-1:0]      mem_addr;
        logic [RASTER_W-1:0]    raster_addr;
        logic                   mem_clk;
        logic                   latch;
        logic                   shift;
        logic                   disp;
        logic                   cursor;
        logic                   flm;
    } state_t;

    state_t q;
    state_t next_q;

    // Indices that name a parameter register
    function automatic logic is_assigned(input logic [4:0] idx);
        unique case (idx)
            IDX_HTOTAL, IDX_HDISP, IDX_MAXRAS, IDX_CSTART, IDX_CEND,
            IDX_SA_HIGH, IDX_SA_LOW, IDX_CA_HIGH, IDX_CA_LOW, IDX_VWIDTH,
            IDX_DUTY_HI, IDX_DUTY_LO, IDX_FRASTER, IDX_MODE:
                is_assigned = 1'b1;
            default:
                is_assigned = 1'b0;
        endcase
    endfunction : is_assigned

    // Indices that read back
    function automatic logic is_readable(input logic [4:0] idx);
        is_readable = (idx == IDX_SA_HIGH) || (idx == IDX_SA_LOW) ||
                      (idx == IDX_CA_HIGH) || (idx == IDX_CA_LOW);
    endfunction : is_readable

    logic                   wr_strobe;
    logic                   rd_active;
    logic                   char_tick;
    logic                   line_end;
    logic [4:0]             mode_eff;
    logic [ADDR_W-1:0]      start_addr;
    logic [ADDR_W-1:0]      cursor_addr;
    logic [DUTY_W-1:0]      duty_count;
    logic [ADDR_W-1:0]      char_addr;
    logic                   in_display;
    logic                   latch_now;
    logic                   blink_on;
    logic                   raster_in_cursor;

    // bus only with chip select low
    assign wr_strobe = !cs_n && !wr_n && !q.wr_low_prev;
    assign rd_active = !cs_n && !rd_n && reg_select_pin;

    assign mode_eff = {on_off_pin, graphic_pin, wide_pin, blink_allow, attr_enable}
                      | q.display_mode;

    assign start_addr  = {q.start_addr_high, q.start_addr_low};
    assign cursor_addr = {q.cursor_addr_high, q.cursor_addr_low};
    // 9-bit rasters per screen, minus one
    assign duty_count  = {q.duty_high, q.duty_low};

    // one character per memory cycle of four dots
    assign char_tick = (q.div == DIV_LAST);
    // line period set by horizontal total
    assign line_end  = (q.hcnt >= q.horizontal_total);
    assign char_addr = ADDR_W'(q.row_addr + ADDR_W'(q.hcnt));
    assign in_display = (q.hcnt <= q.horizontal_displayed);
    // latch window at retrace, at least the last character of each line
    assign latch_now = !in_display || line_end;

    always_comb
    begin
        unique case (q.cursor_start_blink[BLINK_LSB+1:BLINK_LSB])
            BLINK_STEADY: blink_on = 1'b1;
            BLINK_OFF:    blink_on = 1'b0;
            BLINK_32:     blink_on = q.frame[BLINK32_BIT];
            BLINK_64:     blink_on = q.frame[BLINK64_BIT];
        endcase
    end

    assign raster_in_cursor = (q.ras >= q.cursor_start_blink[RASTER_W-1:0]) &&
                              (q.ras <= q.cursor_end);

    always_comb
    begin
        next_q = q;
        next_q.wr_low_prev = !wr_n;
        next_q.div     = 2'(q.div + 2'h1);
        next_q.mem_clk = (next_q.div >= DIV_HALF);

        // index write with register select low
        if (wr_strobe && !reg_select_pin)
        begin
            next_q.index_select = db_in[4:0];
        end
        // unassigned indices fall through without effect
        // indices 23 to 31 also ignored
        if (wr_strobe && reg_select_pin && is_assigned(q.index_select))
        begin
            unique case (q.index_select)
                IDX_HTOTAL:  next_q.horizontal_total     = db_in;
                IDX_HDISP:   next_q.horizontal_displayed = db_in;
                IDX_MAXRAS:  next_q.max_raster           = db_in[4:0];
                IDX_CSTART:  next_q.cursor_start_blink   = db_in[6:0];
                IDX_CEND:    next_q.cursor_end           = db_in[4:0];
                IDX_SA_HIGH: next_q.start_addr_high      = db_in;
                IDX_SA_LOW:  next_q.start_addr_low       = db_in;
                IDX_CA_HIGH: next_q.cursor_addr_high     = db_in;
                IDX_CA_LOW:  next_q.cursor_addr_low      = db_in;
                IDX_VWIDTH:  next_q.virtual_width        = db_in;
                IDX_DUTY_HI: next_q.duty_high            = db_in[0];
                IDX_DUTY_LO: next_q.duty_low             = db_in;
                IDX_FRASTER: next_q.first_raster         = db_in[4:0];
                IDX_MODE:    next_q.display_mode         = db_in[4:0];
                default:     next_q.index_select         = q.index_select;
            endcase
        end

        // read mux for address pairs only
        unique case (q.index_select)
            IDX_SA_HIGH: next_q.db_out = q.start_addr_high;
            IDX_SA_LOW:  next_q.db_out = q.start_addr_low;
            IDX_CA_HIGH: next_q.db_out = q.cursor_addr_high;
            IDX_CA_LOW:  next_q.db_out = q.cursor_addr_low;
            default:     next_q.db_out = REG8_RST;
        endcase

        if (char_tick)
        begin
            if (line_end)
            begin
                next_q.hcnt    = 8'h00;
                next_q.refresh = '0;
                // static duty when count is zero, up to 512 rasters
                if (q.line >= duty_count)
                begin
                    next_q.line     = '0;
                    // frame begins at the first raster
                    next_q.ras      = q.first_raster;
                    next_q.row_addr = start_addr;
                    next_q.frame    = FRAME_W'(q.frame + 1'b1);
                end
                else
                begin
                    next_q.line = DUTY_W'(q.line + 1'b1);
                    if (q.ras >= q.max_raster)
                    begin
                        next_q.ras      = '0;
                        // next row starts one memory row further on
                        next_q.row_addr = ADDR_W'(q.row_addr + ADDR_W'(q.virtual_width));
                    end
                    else
                    begin
                        next_q.ras = RASTER_W'(q.ras + 1'b1);
                    end
                end
            end
            else
            begin
                next_q.hcnt = 8'(q.hcnt + 8'h01);
            end
            next_q.latch = latch_now;
            // display transfer kept out of the latch high period
            next_q.disp  = in_display && !latch_now && mode_eff[MODE_ON];
            // refresh address while latch is high
            if (latch_now)
            begin
                next_q.mem_addr = ADDR_W'(q.refresh);
                next_q.refresh  = REFRESH_W'(q.refresh + 1'b1);
            end
            else
            begin
                next_q.mem_addr = char_addr;
            end
            next_q.raster_addr = q.ras;
            // cursor where the address matches, character mode only
            next_q.cursor = in_display && !latch_now && (char_addr == cursor_addr) &&
                            raster_in_cursor && blink_on && !mode_eff[MODE_GRAPHIC];
            next_q.flm    = (q.line == '0);
        end
        // shift clock idles outside display so memory can be rewritten
        next_q.shift = q.disp && q.div[0];

        if (!reset_n_pin)
        begin
            next_q.div      = '0;
            next_q.mem_clk  = 1'b0;
            next_q.hcnt     = '0;
            next_q.ras      = '0;
            next_q.raster_addr = '0;
            next_q.line     = '0;
            next_q.row_addr = '0;
            next_q.refresh  = '0;
            next_q.frame    = '0;
            next_q.latch    = 1'b0;
            next_q.disp     = 1'b0;
            next_q.shift    = 1'b0;
            next_q.cursor   = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    // write-only registers never drive the bus
    assign db_oe          = rd_active && is_readable(q.index_select);
    assign db_out         = q.db_out;
    assign eff_mode       = mode_eff;
    assign mem_addr       = q.mem_addr;
    assign raster_addr    = q.raster_addr;
    assign mem_clk        = q.mem_clk;
    assign line_latch_clk = q.latch;
    assign shift_clk      = q.shift;
    assign disp_timing    = q.disp;
    assign cursor_disp    = q.cursor;
    assign frame_marker   = q.flm;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    no_overlap_a: assert property (!(q.latch && q.disp))
        else $error("display transfer overlaps line latch");
    mclk_period_a: assert property ($rose(q.mem_clk) && reset_n_pin ##1 reset_n_pin [*3]
                                    |=> $rose(q.mem_clk))
        else $error("memory clock period wrong");
    mclk_div_a: assert property ($rose(q.mem_clk) && reset_n_pin |=> !$rose(q.mem_clk) [*3])
        else $error("memory clock not dot clock over four");
    index_write_a: assert property (wr_strobe && !reg_select_pin |=> q.index_select == $past(db_in[4:0]))
        else $error("index not taken");
    unassigned_a: assert property (wr_strobe && reg_select_pin && !is_assigned(q.index_select)
                                   |=> $stable(q.horizontal_total) && $stable(q.display_mode)
                                       && $stable(q.start_addr_low))
        else $error("unassigned index changed a register");
    read_only_pairs_a: assert property (db_oe |-> is_readable(q.index_select))
        else $error("write-only register drove the bus");
    cs_ignore_a: assert property (cs_n |=> $stable(q.index_select) && $stable(q.start_addr_high))
        else $error("bus taken without chip select");
    reset_pin_a: assert property (!reset_n_pin && !wr_strobe |=> q.hcnt == 8'h00
                                  && q.line == '0 && q.ras == '0 && q.raster_addr == '0
                                  && $stable(q.horizontal_total))
        else $error("reset pin handling wrong");
    refresh_a: assert property (char_tick && latch_now && reset_n_pin
                                |=> q.mem_addr == ADDR_W'($past(q.refresh)))
        else $error("refresh address missing in latch period");
    blink_off_a: assert property (char_tick && q.cursor_start_blink[6:5] == BLINK_OFF
                                  |=> !q.cursor)
        else $error("cursor shown with blink off");
    mode_or_a: assert property (eff_mode[MODE_ON] == (on_off_pin | q.display_mode[MODE_ON]))
        else $error("mode not pin OR register");
    shift_in_disp_a: assert property (q.shift |-> $past(q.disp))
        else $error("shift clock outside display transfer");
    cursor_graphic_a: assert property (char_tick && mode_eff[MODE_GRAPHIC] |=> !q.cursor)
        else $error("cursor shown in graphic mode");
    frame_start_a: assert property (char_tick && line_end && q.line >= duty_count
                                    && reset_n_pin |=> q.line == '0
                                    && q.ras == $past(q.first_raster))
        else $error("frame did not restart at first raster");
    duty_static_a: assert property (char_tick && line_end && duty_count == '0
                                    && reset_n_pin |=> q.line == '0)
        else $error("static duty did not hold line zero");
    raster_wrap_a: assert property (char_tick && line_end && q.line < duty_count
                                    && q.ras >= q.max_raster && reset_n_pin |=> q.ras == '0)
        else $error("raster did not wrap at maximum");
    hi_index_a: assert property (wr_strobe && reg_select_pin && q.index_select > IDX_MODE
                                 |=> $stable(q.display_mode) && $stable(q.duty_low))
        else $error("write through unassigned high index");
    disp_addr_a: assert property (char_tick && !latch_now && reset_n_pin
                                  |=> q.mem_addr == $past(char_addr))
        else $error("display address not on memory address");

    frame_cover: cover property (char_tick && line_end && q.line == duty_count);
    cursor_cover: cover property ($rose(q.cursor));
    readback_cover: cover property (db_oe && q.index_select == IDX_CA_LOW);
    refresh_cover: cover property (q.latch && q.mem_addr != '0);
    blink_off_cover: cover property (char_tick && q.cursor_start_blink[6:5] == BLINK_OFF);
endmodule : lcd_timing_ctrl
`default_nettype wire

// file: hdl/lcd_timing_pkg.sv
// Constants for the LCD timing register set
package lcd_timing_pkg;
    // Parameter register indices
    localparam logic [4:0] IDX_HTOTAL   = 5'h00;
    localparam logic [4:0] IDX_HDISP    = 5'h01;
    localparam logic [4:0] IDX_MAXRAS   = 5'h09;
    localparam logic [4:0] IDX_CSTART   = 5'h0A;
    localparam logic [4:0] IDX_CEND     = 5'h0B;
    localparam logic [4:0] IDX_SA_HIGH  = 5'h0C;
    localparam logic [4:0] IDX_SA_LOW   = 5'h0D;
    localparam logic [4:0] IDX_CA_HIGH  = 5'h0E;
    localparam logic [4:0] IDX_CA_LOW   = 5'h0F;
    localparam logic [4:0] IDX_VWIDTH   = 5'h12;
    localparam logic [4:0] IDX_DUTY_HI  = 5'h13;
    localparam logic [4:0] IDX_DUTY_LO  = 5'h14;
    localparam logic [4:0] IDX_FRASTER  = 5'h15;
    localparam logic [4:0] IDX_MODE     = 5'h16;
    // Field layout
    localparam int RASTER_W      = 5;
    localparam int ADDR_W        = 16;
    localparam int DUTY_W        = 9;
    localparam int REFRESH_W     = 8;
    localparam int FRAME_W       = 6;
    localparam int BLINK_LSB     = 5;
    localparam int MODE_ON       = 4;
    localparam int MODE_GRAPHIC  = 3;
    localparam int MODE_WIDE     = 2;
    localparam int MODE_BLINK    = 1;
    localparam int MODE_ATTR     = 0;
    // Cursor blink modes
    localparam logic [1:0] BLINK_STEADY = 2'h0;
    localparam logic [1:0] BLINK_OFF    = 2'h1;
    localparam logic [1:0] BLINK_32     = 2'h2;
    localparam logic [1:0] BLINK_64     = 2'h3;
    // Frame counter bits that toggle every 16 and 32 frames
    localparam int BLINK32_BIT   = 4;
    localparam int BLINK64_BIT   = 5;
    // Clocking: memory cycle is the dot clock divided by four
    localparam int          CLK_HZ    = 20000000;
    localparam int          MCLK_DIV  = 4;
    localparam logic [1:0]  DIV_LAST  = 2'(MCLK_DIV - 1);
    localparam logic [1:0]  DIV_HALF  = 2'(MCLK_DIV / 2);
    // Register reset values
    localparam logic [7:0]  REG8_RST  = 8'h00;
endpackage : lcd_timing_pkg

// file: hdl/unused_placeholder_none.sv
// Intentionally empty file slot avoided
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: testbench/lcd_host_model.sv
// Host processor model that drives the register bus
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model
(
    // Clock
    input  wire logic       clk,
    // Register bus
    output var  logic       cs_n,
    output var  logic       reg_select_pin,
    output var  logic       wr_n,
    output var  logic       rd_n,
    output var  logic [7:0] db_in,
    input  wire logic [7:0] db_out,
    input  wire logic       db_oe
);
    initial
    begin
        cs_n           = 1'b1;
        reg_select_pin = 1'b0;
        wr_n           = 1'b1;
        rd_n           = 1'b1;
        db_in          = 8'h00;
    end

    task automatic bus_write(input logic sel, input logic [7:0] d, input logic cs_v);
        @(posedge clk);
        cs_n           <= cs_v;
        reg_select_pin <= sel;
        wr_n           <= 1'b0;
        db_in          <= d;
        @(posedge clk);
        cs_n           <= 1'b1;
        wr_n           <= 1'b1;
        db_in          <= ~d;
    endtask : bus_write

    task automatic reg_write(input logic [4:0] idx, input logic [7:0] d);
        bus_write(1'b0, {3'h0, idx}, 1'b0);
        bus_write(1'b1, d, 1'b0);
    endtask : reg_write

    task automatic reg_read(input logic [4:0] idx, output logic [7:0] d, output logic oe);
        bus_write(1'b0, {3'h0, idx}, 1'b0);
        @(posedge clk);
        cs_n           <= 1'b0;
        reg_select_pin <= 1'b1;
        rd_n           <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        d  = db_out;
        oe = db_oe;
        @(posedge clk);
        cs_n           <= 1'b1;
        rd_n           <= 1'b1;
    endtask : reg_read
endmodule : lcd_host_model
`default_nettype wire

// file: testbench/lcd_timing_register_set_tb.sv
// Self-checking testbench for the LCD timing register set
`timescale 1ns/1ps
`default_nettype none
module lcd_timing_register_set_tb;
    import lcd_timing_pkg::*;
    logic        clk, rst, reset_n_pin, cs_n, reg_select_pin, wr_n, rd_n, db_oe;
    logic [7:0]  db_in, db_out, rd_v;
    logic [4:0]  mode_pins, eff_mode, raster_addr;
    logic [15:0] mem_addr;
    logic        mem_clk, line_latch_clk, shift_clk, disp_timing, cursor_disp, frame_marker, oe;
    int          n_fail, n_tests;

    lcd_host_model lcd_host_model_inst (.clk, .cs_n, .reg_select_pin, .wr_n, .rd_n, .db_in,
        .db_out, .db_oe);
    lcd_timing_ctrl lcd_timing_ctrl_inst (.clk, .rst, .reset_n_pin, .cs_n, .reg_select_pin,
        .wr_n, .rd_n, .db_in, .db_out, .db_oe, .on_off_pin(mode_pins[4]),
        .graphic_pin(mode_pins[3]), .wide_pin(mode_pins[2]), .blink_allow(mode_pins[1]),
        .attr_enable(mode_pins[0]), .eff_mode, .mem_addr, .raster_addr, .mem_clk,
        .line_latch_clk, .shift_clk, .disp_timing, .cursor_disp, .frame_marker);

    always #25 clk = ~clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("Counts: %0d compared, %0d mismatched", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    task automatic rd_chk(input logic [4:0] idx, input logic [7:0] exp, input logic exp_oe);
        lcd_host_model_inst.reg_read(idx, rd_v, oe);
        chk({15'h0000, oe}, {15'h0000, exp_oe});
        if (exp_oe)
            chk({8'h00, rd_v}, {8'h00, exp});
    endtask : rd_chk

    task automatic t_readback();
        for (int i = 0; i < 4; i++)
            rd_chk(IDX_SA_HIGH + 5'(i), 8'h00, 1'b1);
        for (int i = 0; i < 4; i++)
            lcd_host_model_inst.reg_write(IDX_SA_HIGH + 5'(i), 8'h81 + 8'(i * 36));
        for (int i = 0; i < 4; i++)
            rd_chk(IDX_SA_HIGH + 5'(i), 8'h81 + 8'(i * 36), 1'b1);
        $display("test readback done");
    endtask : t_readback

    task automatic t_write_only();
        logic [4:0] wo [10] = '{5'h00, 5'h01, 5'h09, 5'h0A, 5'h0B, 5'h12, 5'h13, 5'h14, 5'h15,
                                5'h16};
        foreach (wo[i])
            rd_chk(wo[i], 8'h00, 1'b0);
        rd_chk(IDX_SA_HIGH, 8'h81, 1'b1);
        $display("test write_only done");
    endtask : t_write_only

    task automatic t_ignored();
        logic [4:0] un [8] = '{5'h02, 5'h05, 5'h08, 5'h10, 5'h11, 5'h17, 5'h1C, 5'h1F};
        lcd_host_model_inst.reg_write(IDX_SA_HIGH, 8'h5A);
        foreach (un[i])
            lcd_host_model_inst.reg_write(un[i], 8'hFF);
        lcd_host_model_inst.bus_write(1'b0, {3'h0, IDX_SA_HIGH}, 1'b0);
        lcd_host_model_inst.bus_write(1'b1, 8'hC3, 1'b1);
        rd_chk(IDX_SA_HIGH, 8'h5A, 1'b1);
        rd_chk(IDX_CA_LOW, 8'hED, 1'b1);
        $display("test ignored done");
    endtask : t_ignored

    task automatic t_mode();
        for (int b = 0; b < 5; b++)
        begin
            @(posedge clk);
            mode_pins <= 5'(1 << b);
            lcd_host_model_inst.reg_write(IDX_MODE, 8'h00);
            @(posedge clk);
            #1;
            chk({11'h000, eff_mode}, 16'(1 << b));
            @(posedge clk);
            mode_pins <= 5'h00;
            lcd_host_model_inst.reg_write(IDX_MODE, 8'(1 << b));
            @(posedge clk);
            #1;
            chk({11'h000, eff_mode}, 16'(1 << b));
        end
        $display("test mode done");
    endtask : t_mode

    task automatic t_timing();
        int n_dt = 0, n_ll = 0, n_mc = 0, r_mc = 0, r_ll = 0, both = 0;
        int n_sh = 0, n_fm = 0, n_ma = 0, n_rf = 0, n_cu = 0;
        logic p_mc, p_ll;
        lcd_host_model_inst.reg_write(IDX_HTOTAL, 8'h09);
        lcd_host_model_inst.reg_write(IDX_HDISP, 8'h05);
        lcd_host_model_inst.reg_write(IDX_DUTY_LO, 8'h03);
        lcd_host_model_inst.reg_write(IDX_MAXRAS, 8'h01);
        lcd_host_model_inst.reg_write(IDX_CA_HIGH, 8'h5A);
        lcd_host_model_inst.reg_write(IDX_CA_LOW, 8'hA7);
        repeat (80) @(posedge clk);
        #1;
        {p_mc, p_ll} = {mem_clk, line_latch_clk};
        repeat (160)
        begin
            @(posedge clk);
            #1;
            n_dt += disp_timing;
            n_ll += line_latch_clk;
            n_mc += mem_clk;
            r_mc += (mem_clk && !p_mc);
            r_ll += (line_latch_clk && !p_ll);
            both += (disp_timing && line_latch_clk);
            n_sh += shift_clk;
            n_fm += frame_marker;
            n_cu += cursor_disp;
            n_ma += (disp_timing && mem_addr == 16'h5AA5);
            n_rf += (line_latch_clk && mem_addr[15:8] == 8'h00);
            {p_mc, p_ll} = {mem_clk, line_latch_clk};
        end
        chk(16'(n_dt), 16'h0060);
        chk(16'(n_ll), 16'h0040);
        chk(16'(r_ll), 16'h0004);
        chk(16'(n_mc), 16'h0050);
        chk(16'(r_mc), 16'h0028);
        chk(16'(both), 16'h0000);
        chk(16'(n_sh), 16'h0030);
        chk(16'(n_fm), 16'h0028);
        chk(16'(n_ma), 16'h0010);
        chk(16'(n_rf), 16'h0040);
        chk(16'(n_cu), 16'h0008);
        lcd_host_model_inst.reg_write(IDX_CSTART, 8'h20);
        repeat (8) @(posedge clk);
        n_cu = 0;
        repeat (160)
        begin
            @(posedge clk);
            #1;
            n_cu += cursor_disp;
        end
        chk(16'(n_cu), 16'h0000);
        $display("test timing done");
    endtask : t_timing

    task automatic t_counter_clear();
        @(posedge clk);
        reset_n_pin <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({13'h0000, mem_clk, disp_timing, line_latch_clk}, 16'h0000);
        chk({11'h000, raster_addr}, 16'h0000);
        @(posedge clk);
        reset_n_pin <= 1'b1;
        rd_chk(IDX_SA_HIGH, 8'h5A, 1'b1);
        $display("test counter_clear done");
    endtask : t_counter_clear

    initial
    begin
        {clk, rst, reset_n_pin, mode_pins, n_fail, n_tests} = {3'b011, 5'h00, 64'h0};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_readback();
        t_write_only();
        t_ignored();
        t_mode();
        t_timing();
        t_counter_clear();
        close_out();
    end

    initial
    begin
        repeat (30000) @(posedge clk);
        n_fail++;
        $display("Run did not complete in time");
        close_out();
    end
endmodule : lcd_timing_register_set_tb
`default_nettype wire
